//--- ladder_reference_map.svh
// register offsets, field positions and reset values of the ladder reference control
// assumes inclusion by bare name from the package and design files
`ifndef LADDER_REFERENCE_MAP_SVH
`define LADDER_REFERENCE_MAP_SVH
`define REF_CTRL_OFFSET 8'h9F
`define REF_CTRL_RESET 8'h00
`define REF_POWER_BIT 7
`define REF_PIN_OE_BIT 6
`define REF_RANGE_BIT 5
`define REF_UNUSED_BIT 4
`define REF_CODE_MSB 3
`define REF_CODE_LSB 0
`define REF_LOW_DIV 24
`define REF_HIGH_DIV 32
`define REF_HIGH_BASE_32 8
`define REF_IMPL_MASK 8'hEF
`define REF_LEVEL_RESET 7'h00
`endif

//--- ladder_reference_pkg.sv
// types shared by the ladder reference control
// assumes the map header sits in the same folder
`include "ladder_reference_map.svh"
package ladder_reference_pkg;
    typedef struct packed {
        logic power_enable;
        logic pin_output_enable;
        logic range_select;
        logic [3:0] level_code;
    } ref_ctrl_t;
    typedef struct packed {
        logic range_select;
        logic [3:0] level_code;
    } tap_sel_t;
endpackage

//--- ref_level_calc.sv
// computes the ideal reference level as a fraction of supply, in 1/96 steps
// assumes tap select settled by caller; purely combinational
`timescale 1ns/10ps
`default_nettype none
module ref_level_calc
    import ladder_reference_pkg::*;
(
    input wire tap_sel_t sel, // range and code
    output logic [6:0] level_96 // level in 96ths of supply
);
    always_comb
    begin
        if (sel.range_select)
            level_96 = {1'b0, sel.level_code, 2'b00};
        else
            level_96 = 7'h18 + 7'h03 * {3'h0, sel.level_code};
    end
endmodule
`default_nettype wire

//--- ref_pin_gate.sv
// gates the reference onto its pin from power, direction and output enable
// assumes direction bit 1 means input
`timescale 1ns/10ps
`default_nettype none
module ref_pin_gate
(
    input wire logic power_on, // reference powered
    input wire logic pin_oe, // pin output enable bit
    input wire logic pin_is_input, // pin direction bit
    output logic attach // connect reference to pin
);
    assign attach = power_on && pin_oe && pin_is_input;
endmodule
`default_nettype wire

//--- ladder_reference_control.sv
// control register and tap select of the 16-tap ladder reference
// assumes one clock, synchronous active high reset, plain register port
`timescale 1ns/10ps
`default_nettype none
`include "ladder_reference_map.svh"
module ladder_reference_control
    import ladder_reference_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // device reset
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata_ff, // read data
    input wire logic sleep_mode, // device asleep
    input wire logic port_a_direction_2, // pin direction, 1 input
    output logic ref_power_enable_ff, // ladder power
    output logic ref_output_pin_oe_ff, // attach ladder to pin
    output tap_sel_t tap_sel_ff, // ladder tap select
    output logic [6:0] level_96_ff // ideal level in 96ths of supply
);
    // control register and decoded strobes
    ref_ctrl_t ctrl_ff;
    ref_ctrl_t nxt_ctrl;
    logic hit;
    logic wr_hit;
    logic rd_hit;

    // pin gate and level model
    logic attach;
    logic [6:0] level_96;
    tap_sel_t cur_tap;

    // read path
    logic [7:0] ctrl_word;
    logic [7:0] impl_mask;
    logic [7:0] read_word;

    // write data as it would land on the tap select
    tap_sel_t wr_tap;

    // only one address is decoded; all others are ignored
    assign hit = (addr == `REF_CTRL_OFFSET);
    assign wr_hit = wr && hit;
    assign rd_hit = rd && hit;
    assign impl_mask = `REF_IMPL_MASK;
    assign cur_tap = tap_sel_t'({ctrl_ff.range_select, ctrl_ff.level_code});
    assign wr_tap = tap_sel_t'({wdata[`REF_RANGE_BIT], wdata[`REF_CODE_MSB:`REF_CODE_LSB]});

    // sleep has no effect on the register
    // bit 4 has no storage, so a write to it is dropped
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (wr_hit)
        begin
            nxt_ctrl.power_enable = wdata[`REF_POWER_BIT];
            nxt_ctrl.pin_output_enable = wdata[`REF_PIN_OE_BIT];
            nxt_ctrl.range_select = wdata[`REF_RANGE_BIT];
            nxt_ctrl.level_code = wdata[`REF_CODE_MSB:`REF_CODE_LSB];
        end
    end

    // every implemented field loads on the write edge
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_ff <= ref_ctrl_t'(7'h00);
        else
            ctrl_ff <= nxt_ctrl;
    end

    // stored fields placed at their byte positions
    always_comb
    begin
        ctrl_word = 8'h00;
        ctrl_word[`REF_POWER_BIT] = ctrl_ff.power_enable;
        ctrl_word[`REF_PIN_OE_BIT] = ctrl_ff.pin_output_enable;
        ctrl_word[`REF_RANGE_BIT] = ctrl_ff.range_select;
        ctrl_word[`REF_CODE_MSB:`REF_CODE_LSB] = ctrl_ff.level_code;
    end

    // unimplemented bits masked off one by one
    for (genvar i = 0; i < 8; i++)
    begin : g_read_bit
        assign read_word[i] = ctrl_word[i] & impl_mask[i];
    end

    // read data stands for one cycle only, zero otherwise
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_ff <= 8'h00;
        else if (rd_hit)
            rdata_ff <= read_word;
        else
            rdata_ff <= 8'h00;
    end

    // reference reaches the pin only when powered, enabled and input
    ref_pin_gate ref_pin_gate_inst
    (
        .power_on(ctrl_ff.power_enable),
        .pin_oe(ctrl_ff.pin_output_enable),
        .pin_is_input(port_a_direction_2),
        .attach(attach)
    );

    // ideal level of the selected tap
    ref_level_calc ref_level_calc_inst
    (
        .sel(cur_tap),
        .level_96(level_96)
    );

    // ladder power follows the stored enable one cycle later
    always_ff @(posedge clk)
    begin
        if (rst)
            ref_power_enable_ff <= 1'b0;
        else
            ref_power_enable_ff <= ctrl_ff.power_enable;
    end

    // pin attach follows the gate one cycle later
    always_ff @(posedge clk)
    begin
        if (rst)
            ref_output_pin_oe_ff <= 1'b0;
        else
            ref_output_pin_oe_ff <= attach;
    end

    // tap select lags the register by one cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            tap_sel_ff <= tap_sel_t'(5'h00);
        else
            tap_sel_ff <= cur_tap;
    end

    // level model moves together with the tap select
    always_ff @(posedge clk)
    begin
        if (rst)
            level_96_ff <= `REF_LEVEL_RESET;
        else
            level_96_ff <= level_96;
    end

    // bus steps the checks are built from
    sequence s_ctrl_write;
        wr_hit;
    endsequence

    sequence s_write_then_quiet;
        wr_hit ##1 !wr_hit;
    endsequence

    sequence s_low_write;
        (wr_hit && wdata[`REF_RANGE_BIT]) ##1 !wr_hit;
    endsequence

    sequence s_high_write;
        (wr_hit && !wdata[`REF_RANGE_BIT]) ##1 !wr_hit;
    endsequence

    sequence s_write_then_read;
        wr_hit ##1 rd_hit;
    endsequence

    // write path
    a_write_to_tap: assert property (
        @(posedge clk) disable iff (rst)
        s_ctrl_write |-> ##2 (tap_sel_ff == $past(wr_tap, 2))
    )
    else
        $error("tap select not loaded from write");

    a_code_follows: assert property (
        @(posedge clk) disable iff (rst)
        s_ctrl_write |-> ##2 (tap_sel_ff.level_code == $past(wdata[`REF_CODE_MSB:`REF_CODE_LSB], 2))
    )
    else
        $error("level code not loaded from write");

    a_range_follows: assert property (
        @(posedge clk) disable iff (rst)
        s_ctrl_write |-> ##2 (tap_sel_ff.range_select == $past(wdata[`REF_RANGE_BIT], 2))
    )
    else
        $error("range select not loaded from write");

    a_power_follows: assert property (
        @(posedge clk) disable iff (rst)
        s_ctrl_write |-> ##2 (ref_power_enable_ff == $past(wdata[`REF_POWER_BIT], 2))
    )
    else
        $error("power enable wrong");

    a_write_elsewhere: assert property (
        @(posedge clk) disable iff (rst)
        (wr && !hit) |=> (ctrl_ff == $past(ctrl_ff))
    )
    else
        $error("write to other address changed register");

    // pin path
    a_pin_oe_follows: assert property (
        @(posedge clk) disable iff (rst)
        s_write_then_quiet |-> ##2 (ref_output_pin_oe_ff ==
            ($past(wdata[`REF_POWER_BIT] && wdata[`REF_PIN_OE_BIT], 3) && $past(port_a_direction_2)))
    )
    else
        $error("pin attach does not follow write");

    a_pin_gate: assert property (
        @(posedge clk) disable iff (rst)
        ref_output_pin_oe_ff |-> $past(ctrl_ff.pin_output_enable && port_a_direction_2 && ctrl_ff.power_enable)
    )
    else
        $error("pin attached without enable and input");

    a_pin_needs_input: assert property (
        @(posedge clk) disable iff (rst)
        ref_output_pin_oe_ff |-> $past(port_a_direction_2)
    )
    else
        $error("pin attached while pin is output");

    a_power_gates_pin: assert property (
        @(posedge clk) disable iff (rst)
        ref_output_pin_oe_ff |-> ref_power_enable_ff
    )
    else
        $error("pin attached while ladder unpowered");

    // level model
    a_low_range: assert property (
        @(posedge clk) disable iff (rst)
        s_low_write |-> ##2 (level_96_ff == {1'b0, $past(wdata[`REF_CODE_MSB:`REF_CODE_LSB], 3), 2'b00})
    )
    else
        $error("low range level wrong");

    a_high_range: assert property (
        @(posedge clk) disable iff (rst)
        s_high_write |-> ##2 (level_96_ff == 7'h18 + 7'h03 * {3'h0, $past(wdata[`REF_CODE_MSB:`REF_CODE_LSB], 3)})
    )
    else
        $error("high range level wrong");

    a_level_tracks_tap: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> (level_96_ff == (tap_sel_ff.range_select ? {1'b0, tap_sel_ff.level_code, 2'b00} :
            7'h18 + 7'h03 * {3'h0, tap_sel_ff.level_code}))
    )
    else
        $error("level does not match tap select");

    // retention
    a_sleep_holds: assert property (
        @(posedge clk) disable iff (rst)
        !wr_hit |=> (ctrl_ff == $past(ctrl_ff))
    )
    else
        $error("register changed without write");

    a_sleep_keeps: assert property (
        @(posedge clk) disable iff (rst)
        (sleep_mode && !wr_hit) |=> (ctrl_ff == $past(ctrl_ff))
    )
    else
        $error("register changed during sleep");

    // reset
    a_reset_clears: assert property (
        @(posedge clk)
        rst |=> (ctrl_ff == ref_ctrl_t'(7'h00))
    )
    else
        $error("reset did not clear register");

    a_reset_outputs: assert property (
        @(posedge clk)
        rst |=> (!ref_power_enable_ff && !ref_output_pin_oe_ff && tap_sel_ff == tap_sel_t'(5'h00))
    )
    else
        $error("reset did not clear outputs");

    a_reset_level: assert property (
        @(posedge clk)
        rst |=> (level_96_ff == `REF_LEVEL_RESET)
    )
    else
        $error("reset did not clear level");

    // read path
    a_unused_bit_zero: assert property (
        @(posedge clk) disable iff (rst)
        rd_hit |=> (rdata_ff[`REF_UNUSED_BIT] == 1'b0)
    )
    else
        $error("unused bit read nonzero");

    a_read_other_zero: assert property (
        @(posedge clk) disable iff (rst)
        (rd && !hit) |=> (rdata_ff == 8'h00)
    )
    else
        $error("read of other address nonzero");

    a_read_idle_zero: assert property (
        @(posedge clk) disable iff (rst)
        !rd_hit |=> (rdata_ff == 8'h00)
    )
    else
        $error("read data outside its cycle");

    a_readback: assert property (
        @(posedge clk) disable iff (rst)
        s_write_then_read |=> (rdata_ff == ($past(wdata, 2) & `REF_IMPL_MASK))
    )
    else
        $error("readback mismatch");

endmodule
`default_nettype wire

//--- ladder_reference_control_tb_top.sv
// self-checking testbench for the ladder reference control register
// assumes the package and map header compile first; bench drives all ports
`timescale 1ns/10ps
`default_nettype none
`include "ladder_reference_map.svh"
module ladder_reference_control_tb_top;
import ladder_reference_pkg::*;
logic clk = 0, rst = 1, wr = 0, rd = 0, sleep_mode = 0, port_a_direction_2 = 1;
logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_ff;
logic ref_power_enable_ff, ref_output_pin_oe_ff;
tap_sel_t tap_sel_ff;
logic [6:0] level_96_ff;
int bad_count = 0, num_checks = 0;
always #5 clk = ~clk;
ladder_reference_control ladder_reference_control_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .sleep_mode(sleep_mode), .port_a_direction_2(port_a_direction_2),
    .ref_power_enable_ff(ref_power_enable_ff), .ref_output_pin_oe_ff(ref_output_pin_oe_ff),
    .tap_sel_ff(tap_sel_ff), .level_96_ff(level_96_ff));
task test_done;
    $display("mismatches %0d checks %0d", bad_count, num_checks);
    if (bad_count == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
endtask
task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata_ff;
endtask
// ideal level in 96ths of supply
function automatic logic [7:0] lvl(input logic [4:0] t);
    lvl = t[4] ? {2'b0, t[3:0], 2'b0} : 8'h18 + {4'h0, t[3:0]} * 8'h03;
endfunction
task check_state(input logic [7:0] e);
    logic [7:0] r;
    chk({7'h0, ref_power_enable_ff}, {7'h0, e[7]});
    chk({7'h0, ref_output_pin_oe_ff}, {7'h0, e[7] & e[6] & port_a_direction_2});
    chk({3'h0, tap_sel_ff}, {3'h0, e[5], e[3:0]});
    chk({1'b0, level_96_ff}, lvl({e[5], e[3:0]}));
    rd_reg(`REF_CTRL_OFFSET, r);
    chk(r, e & 8'hEF);
endtask
task t_walk;
    wr_reg(`REF_CTRL_OFFSET, 8'hA6);
    check_state(8'hA6);
endtask
task t_pin;
    wr_reg(`REF_CTRL_OFFSET, 8'hF5);
    check_state(8'hF5);
    port_a_direction_2 <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_state(8'hF5);
    port_a_direction_2 <= 1'b1;
    wr_reg(`REF_CTRL_OFFSET, 8'h3A);
    check_state(8'h3A);
endtask
task t_codes;
    for (int i = 0; i < 32; i++)
    begin
        wr_reg(`REF_CTRL_OFFSET, {2'b11, i[4], 1'b0, i[3:0]});
        check_state({2'b11, i[4], 1'b0, i[3:0]});
    end
endtask
task t_unmapped_sleep;
    logic [7:0] r;
    wr_reg(`REF_CTRL_OFFSET, 8'hE9);
    wr_reg(8'h9E, 8'h00);
    rd_reg(8'h9E, r);
    chk(r, 8'h00);
    check_state(8'hE9);
    sleep_mode <= 1'b1;
    repeat (20) @(posedge clk);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check_state(8'hE9);
    wr_reg(`REF_CTRL_OFFSET, 8'h29);
    sleep_mode <= 1'b1;
    repeat (20) @(posedge clk);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check_state(8'h29);
endtask
task t_back_to_back;
    @(posedge clk);
    addr <= `REF_CTRL_OFFSET;
    wdata <= 8'h5C;
    wr <= 1'b1;
    @(posedge clk);
    wdata <= 8'h97;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata_ff, 8'h87);
    @(posedge clk);
    #1;
    check_state(8'h97);
endtask
task t_reset_mid;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_state(8'h00);
endtask
initial
begin
    #50000;
    bad_count++;
    test_done();
end
initial
begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_state(8'h00);
    t_walk();
    t_pin();
    t_codes();
    t_unmapped_sleep();
    t_back_to_back();
    t_reset_mid();
    test_done();
end
endmodule
`default_nettype wire
